//--- csm_pkg.sv
package csm_pkg;
  localparam int LMI_ADDR_W  = 12;
  localparam int LMI_DATA_W  = 32;
  localparam int WORD_LSB    = 2;
  localparam int IDX_W       = LMI_ADDR_W - WORD_LSB;
  localparam int RC_ADDR_W   = 8;
  localparam int RC_DATA_W   = 16;
  localparam int RC_BE_W     = 2;
  localparam int BUSDEV_W    = 13;
  localparam int CLK_MHZ     = 100;
  localparam int LMI_MAX_MHZ = 250;
  localparam int RC_MAX_MHZ  = 50;
  // Give up on a missing acknowledge after this long
  localparam int ACK_WAIT_NS  = 640;
  localparam int ACK_WAIT_CYC = (ACK_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int CFG_WORDS    = 128;
  localparam int RC_REGS      = 16;
  localparam logic [RC_DATA_W-1:0]  RC_RESET_VAL   = 16'h0000;
  localparam logic [IDX_W-1:0]      AER_LOG_FIRST  = 10'h047;
  localparam logic [IDX_W-1:0]      AER_LOG_LAST   = 10'h04A;
  localparam logic [IDX_W-1:0]      CMD_STAT_IDX   = 10'h001;
  localparam logic [LMI_DATA_W-1:0] CMD_STAT_WMASK = 32'h0000_FFFF;
  localparam logic [LMI_DATA_W-1:0] ALL_WMASK      = 32'hFFFF_FFFF;
  localparam logic [LMI_DATA_W-1:0] NO_WMASK       = 32'h0000_0000;

  function automatic logic is_aer_log(input logic [IDX_W-1:0] idx);
    return (idx >= AER_LOG_FIRST) && (idx <= AER_LOG_LAST);
  endfunction

  // Writable bits of one configuration word; all else is read-only
  function automatic logic [LMI_DATA_W-1:0] wmask(input logic [IDX_W-1:0] idx);
    if (is_aer_log(idx)) begin
      return ALL_WMASK;
    end else if (idx == CMD_STAT_IDX) begin
      return CMD_STAT_WMASK;
    end
    return NO_WMASK;
  endfunction
endpackage

//--- csm_if.sv
interface csm_if (
  input wire logic clock,  // Fabric clock shared by both ends
  input wire logic rst_n   // System reset, active low
);
  logic [csm_pkg::LMI_ADDR_W-1:0] lmi_address;
  logic [csm_pkg::LMI_DATA_W-1:0] lmi_wdata;
  logic [csm_pkg::LMI_DATA_W-1:0] lmi_rdata;
  logic                           lmi_rd;
  logic                           lmi_wr;
  logic                           lmi_ack;
  logic [csm_pkg::RC_ADDR_W-1:0]  rc_address;
  logic [csm_pkg::RC_BE_W-1:0]    rc_byteenable;
  logic                           rc_chipselect;
  logic                           rc_read;
  logic                           rc_write;
  logic [csm_pkg::RC_DATA_W-1:0]  rc_writedata;
  logic                           rc_waitrequest;
  logic [csm_pkg::RC_DATA_W-1:0]  rc_readdata;
  logic                           rc_readdatavalid;
  logic                           rc_rst_n;

  modport dev (
    input  clock, rst_n, lmi_address, lmi_wdata, lmi_rd, lmi_wr,
    input  rc_address, rc_byteenable, rc_chipselect, rc_read, rc_write, rc_writedata, rc_rst_n,
    output lmi_rdata, lmi_ack, rc_waitrequest, rc_readdata, rc_readdatavalid
  );
  modport app (
    input  clock, rst_n, lmi_rdata, lmi_ack, rc_waitrequest, rc_readdata, rc_readdatavalid,
    output lmi_address, lmi_wdata, lmi_rd, lmi_wr,
    output rc_address, rc_byteenable, rc_chipselect, rc_read, rc_write, rc_writedata, rc_rst_n
  );
endinterface

//--- csm_rc_regs.sv
module csm_rc_regs #(
  parameter int REGS = csm_pkg::RC_REGS
) (
  input  wire logic                                clock,          // Fabric clock
  input  wire logic                                rc_rst_n,       // Reconfiguration reset, active low
  input  wire logic [csm_pkg::RC_ADDR_W-1:0]       address,        // Register address
  input  wire logic [csm_pkg::RC_BE_W-1:0]         byteenable,     // Accepted but unused
  input  wire logic                                chipselect,     // Slave select
  input  wire logic                                read,           // Read request
  input  wire logic                                write,          // Write request
  input  wire logic [csm_pkg::RC_DATA_W-1:0]       writedata,      // Write data
  output logic                                     waitrequest,    // Slave cannot take a request
  output logic [csm_pkg::RC_DATA_W-1:0]            readdata,       // Read data
  output logic                                     readdatavalid,  // Qualifies readdata
  output logic [REGS-1:0][csm_pkg::RC_DATA_W-1:0]  values          // Override values for the store
);
  localparam int SEL_W = $clog2(REGS);

  logic [REGS-1:0][csm_pkg::RC_DATA_W-1:0] regs;
  wire logic                               take    = chipselect && (read || write) && !waitrequest;
  wire logic                               in_map  = address < csm_pkg::RC_ADDR_W'(REGS);
  wire logic [SEL_W-1:0]                   sel     = address[SEL_W-1:0];
  // R14 byte enables ignored
  wire logic                               be_seen = |byteenable;
  wire logic [csm_pkg::RC_DATA_W-1:0]      rd_word = in_map ? regs[sel] : '0;

  assign values = regs;

  // R19 reset restores defaults
  for (genvar g = 0; g < REGS; g++) begin : g_reg
    always_ff @(posedge clock or negedge rc_rst_n) begin
      if (!rc_rst_n) begin
        regs[g] <= csm_pkg::RC_RESET_VAL;
      // R13 overwrite read-only values
      end else if (take && write && in_map && sel == SEL_W'(g)) begin
        regs[g] <= writedata;
      end
    end
  end

  // R15 busy for one cycle after acceptance, R16 also high in reset
  always_ff @(posedge clock or negedge rc_rst_n) begin
    if (!rc_rst_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= take || (be_seen && 1'b0);
    end
  end

  // R17 read data qualified by valid
  always_ff @(posedge clock or negedge rc_rst_n) begin
    if (!rc_rst_n) begin
      readdatavalid <= 1'b0;
      readdata      <= '0;
    end else begin
      readdatavalid <= take && read && !write;
      if (take && read && !write) begin
        readdata <= rd_word;
      end
    end
  end
endmodule // csm_rc_regs

//--- csm_device.sv
// Function
// R1: management port runs on fabric clock, 250 MHz max
// R2: 12-bit byte address, low two bits ignored
// R3: management data always 32 bits both ways
// R4: bits keep link-side access attributes
// R5: acknowledge marks write done or read valid
// R6: read data held until next read
// R7: writes change only writable bits
// R8: application writes header log via management port
// R9: application avoids other management writes
// R10: management write corrupts captured bus/device number
// R11: collision with link request may drop acknowledge
// R12: reconfiguration slave: 8-bit address, 16-bit data
// R13: reconfiguration writes change read-only values
// R14: reconfiguration byte enables ignored
// R15: waitrequest stalls; master holds its inputs
// R16: waitrequest may be high when idle
// R17: reconfiguration read data has valid strobe
// R18: reconfiguration clock at most 50 MHz; here it is the fabric clock, 100 MHz
// R19: reconfiguration reset restores register defaults
// R20: one strobe, one outstanding management request
module csm_device #(
  parameter int WORDS   = csm_pkg::CFG_WORDS,
  parameter int RC_REGS = csm_pkg::RC_REGS
) (
  csm_if.dev                              bus,            // Management and reconfiguration ports
  input  wire logic                       link_req,       // Link configuration request, one cycle
  input  wire logic                       link_wr,        // Request is a write
  input  wire logic [csm_pkg::LMI_ADDR_W-1:0] link_addr,  // Link request byte address
  input  wire logic [csm_pkg::LMI_DATA_W-1:0] link_wdata, // Link write data
  input  wire logic [csm_pkg::BUSDEV_W-1:0]   link_busdev,// Bus/device number carried by the link write
  output logic [csm_pkg::LMI_DATA_W-1:0]      link_rdata, // Link read data
  output logic                                link_done,  // Link request completed
  output logic [csm_pkg::BUSDEV_W-1:0]        busdev      // Captured bus/device number
);
  localparam int DW    = csm_pkg::LMI_DATA_W;
  localparam int IW    = csm_pkg::IDX_W;
  localparam int RDW   = csm_pkg::RC_DATA_W;
  localparam int HALFS = DW / RDW;

  logic [DW-1:0]                stored [WORDS];
  logic [WORDS-1:0][DW-1:0]     view;
  logic [RC_REGS-1:0][RDW-1:0]  rc_values;
  wire logic                    clock_w = bus.clock;

  // R2 word index from byte address
  wire logic [IW-1:0] lmi_idx  = bus.lmi_address[csm_pkg::LMI_ADDR_W-1:csm_pkg::WORD_LSB];
  wire logic [IW-1:0] link_idx = link_addr[csm_pkg::LMI_ADDR_W-1:csm_pkg::WORD_LSB];

  // R11 a coinciding link request wins and the management one is dropped
  wire logic lmi_busy = link_req;
  wire logic lmi_rd   = bus.lmi_rd && !lmi_busy;
  wire logic lmi_wr   = bus.lmi_wr && !bus.lmi_rd && !lmi_busy;
  wire logic link_rd  = link_req && !link_wr;
  wire logic link_wrt = link_req && link_wr;

  wire logic [IW-1:0] wr_idx  = link_wrt ? link_idx : lmi_idx;
  wire logic [DW-1:0] wr_data = link_wrt ? link_wdata : bus.lmi_wdata;
  wire logic          wr_en   = link_wrt || lmi_wr;
  // R4 same mask for link and management writes
  wire logic [DW-1:0] wr_mask = csm_pkg::wmask(wr_idx);

  wire logic          lmi_in_map  = lmi_idx < IW'(WORDS);
  wire logic          link_in_map = link_idx < IW'(WORDS);
  wire logic [DW-1:0] lmi_word    = lmi_in_map ? view[lmi_idx[$clog2(WORDS)-1:0]] : '0;
  wire logic [DW-1:0] link_word   = link_in_map ? view[link_idx[$clog2(WORDS)-1:0]] : '0;

  // Read-only value of a word: reconfiguration halves for the low words, else zero
  function automatic logic [DW-1:0] ro_value(input int w, input logic [RC_REGS-1:0][RDW-1:0] rc);
    logic [DW-1:0] v;
    v = '0;
    for (int h = 0; h < HALFS; h++) begin
      if (w * HALFS + h < RC_REGS) begin
        v[h*RDW +: RDW] = rc[w * HALFS + h];
      end
    end
    return v;
  endfunction

  for (genvar g = 0; g < WORDS; g++) begin : g_word
    localparam logic [IW-1:0] IDX = IW'(g);
    wire logic [DW-1:0] mask = csm_pkg::wmask(IDX);

    // R13 read-only bits come from reconfiguration values
    assign view[g] = (stored[g] & mask) | (ro_value(g, rc_values) & ~mask);

    // R7 only writable bits are written
    always_ff @(posedge clock_w or negedge bus.rst_n) begin
      if (!bus.rst_n) begin
        stored[g] <= '0;
      end else if (wr_en && wr_idx == IDX) begin
        stored[g] <= (stored[g] & ~wr_mask) | (wr_data & wr_mask);
      end
    end
  end

  // R1 management port is synchronous to the fabric clock
  // R5 acknowledge one cycle after a taken request
  always_ff @(posedge clock_w or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      bus.lmi_ack <= 1'b0;
    end else begin
      bus.lmi_ack <= lmi_rd || lmi_wr;
    end
  end

  // R6 read data held until the next read
  // R3 full 32-bit word returned
  always_ff @(posedge clock_w or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      bus.lmi_rdata <= '0;
    end else if (lmi_rd) begin
      bus.lmi_rdata <= lmi_word;
    end
  end

  // R10 link write sets, management write corrupts
  always_ff @(posedge clock_w or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      busdev <= '0;
    end else if (link_wrt) begin
      busdev <= link_busdev;
    end else if (lmi_wr) begin
      busdev <= bus.lmi_wdata[csm_pkg::BUSDEV_W-1:0];
    end
  end

  always_ff @(posedge clock_w or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      link_done  <= 1'b0;
      link_rdata <= '0;
    end else begin
      link_done <= link_req;
      if (link_rd) begin
        link_rdata <= link_word;
      end
    end
  end

  // R12 8-bit address, 16-bit data slave
  csm_rc_regs #(
    .REGS (RC_REGS)
  ) u_rc (
    .clock         (clock_w),
    .rc_rst_n      (bus.rc_rst_n),
    .address       (bus.rc_address),
    .byteenable    (bus.rc_byteenable),
    .chipselect    (bus.rc_chipselect),
    .read          (bus.rc_read),
    .write         (bus.rc_write),
    .writedata     (bus.rc_writedata),
    .waitrequest   (bus.rc_waitrequest),
    .readdata      (bus.rc_readdata),
    .readdatavalid (bus.rc_readdatavalid),
    .values        (rc_values)
  );
endmodule // csm_device

//--- csm_app.sv
module csm_app #(
  parameter int ACK_WAIT = csm_pkg::ACK_WAIT_CYC
) (
  csm_if.app                                   bus,        // Management and reconfiguration ports
  input  wire logic                            cmd_rd,     // Management read request, one cycle
  input  wire logic                            cmd_wr,     // Management write request, one cycle
  input  wire logic [csm_pkg::LMI_ADDR_W-1:0]  cmd_addr,   // Management byte address
  input  wire logic [csm_pkg::LMI_DATA_W-1:0]  cmd_wdata,  // Management write data
  input  wire logic                            wr_unlock,  // Permit writes outside the header log
  output logic                                 cmd_busy,   // Management request outstanding
  output logic                                 cmd_done,   // Acknowledged, one cycle
  output logic                                 cmd_fail,   // Refused or timed out, one cycle
  output logic [csm_pkg::LMI_DATA_W-1:0]       cmd_rdata,  // Last read data
  input  wire logic                            rc_rd,      // Reconfiguration read request
  input  wire logic                            rc_wr,      // Reconfiguration write request
  input  wire logic [csm_pkg::RC_ADDR_W-1:0]   rc_addr,    // Reconfiguration address
  input  wire logic [csm_pkg::RC_DATA_W-1:0]   rc_wdata,   // Reconfiguration write data
  input  wire logic                            rc_reset,   // Reset the reconfiguration registers
  output logic                                 rc_busy,    // Reconfiguration access outstanding
  output logic                                 rc_rvalid,  // Reconfiguration read data valid
  output logic [csm_pkg::RC_DATA_W-1:0]        rc_rdata    // Reconfiguration read data
);
  localparam int CW = $clog2(ACK_WAIT + 1);

  logic [CW-1:0] wait_cnt;
  logic          rc_pending;

  // R8 header log words always writable; R9 others need unlock
  wire logic in_log   = csm_pkg::is_aer_log(cmd_addr[csm_pkg::LMI_ADDR_W-1:csm_pkg::WORD_LSB]);
  wire logic wr_ok    = in_log || wr_unlock;
  // R20 one strobe, one request outstanding
  wire logic issue_rd = cmd_rd && !cmd_wr && !cmd_busy;
  wire logic issue_wr = cmd_wr && !cmd_rd && !cmd_busy && wr_ok;
  wire logic refused  = (cmd_rd || cmd_wr) && !issue_rd && !issue_wr;
  // R11 a lost acknowledge ends in a timeout
  wire logic timeout  = cmd_busy && !bus.lmi_ack && wait_cnt == CW'(ACK_WAIT);

  // R1 all on the fabric clock; R2 R3 byte address and data
  always_ff @(posedge bus.clock or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      bus.lmi_rd      <= 1'b0;
      bus.lmi_wr      <= 1'b0;
      bus.lmi_address <= '0;
      bus.lmi_wdata   <= '0;
    end else begin
      bus.lmi_rd <= issue_rd;
      bus.lmi_wr <= issue_wr;
      if (issue_rd || issue_wr) begin
        bus.lmi_address <= cmd_addr;
        bus.lmi_wdata   <= cmd_wdata;
      end
    end
  end

  always_ff @(posedge bus.clock or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      cmd_busy  <= 1'b0;
      cmd_done  <= 1'b0;
      cmd_fail  <= 1'b0;
      cmd_rdata <= '0;
      wait_cnt  <= '0;
    end else begin
      cmd_done <= cmd_busy && bus.lmi_ack;
      cmd_fail <= refused || timeout;
      if (issue_rd || issue_wr) begin
        cmd_busy <= 1'b1;
        wait_cnt <= '0;
      end else if (bus.lmi_ack || timeout) begin
        cmd_busy <= 1'b0;
      end else if (cmd_busy) begin
        wait_cnt <= wait_cnt + CW'(1);
      end
      if (cmd_busy && bus.lmi_ack && !bus.lmi_wr) begin
        cmd_rdata <= bus.lmi_rdata;
      end
    end
  end

  // R12 R15 R16 reconfiguration master: start any time, hold while stalled
  // R18 runs on the fabric clock, 100 MHz, above the 50 MHz slave limit
  wire logic rc_issue = (rc_rd || rc_wr) && !rc_busy;
  wire logic rc_taken = bus.rc_chipselect && !bus.rc_waitrequest;

  always_ff @(posedge bus.clock or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      bus.rc_chipselect <= 1'b0;
      bus.rc_read       <= 1'b0;
      bus.rc_write      <= 1'b0;
      bus.rc_address    <= '0;
      bus.rc_writedata  <= '0;
      bus.rc_byteenable <= '0;
      bus.rc_rst_n      <= 1'b0;
      rc_busy           <= 1'b0;
      rc_pending        <= 1'b0;
      rc_rvalid         <= 1'b0;
      rc_rdata          <= '0;
    end else begin
      // R19 reconfiguration reset from the user side
      bus.rc_rst_n <= !rc_reset;
      rc_rvalid    <= bus.rc_readdatavalid && rc_pending;
      if (bus.rc_readdatavalid) begin
        rc_rdata <= bus.rc_readdata;
      end
      if (rc_issue) begin
        bus.rc_chipselect <= 1'b1;
        bus.rc_read       <= rc_rd;
        bus.rc_write      <= rc_wr && !rc_rd;
        bus.rc_address    <= rc_addr;
        bus.rc_writedata  <= rc_wdata;
        // R14 full word always
        bus.rc_byteenable <= '1;
        rc_busy           <= 1'b1;
      end else if (rc_taken) begin
        bus.rc_chipselect <= 1'b0;
        bus.rc_read       <= 1'b0;
        bus.rc_write      <= 1'b0;
        rc_pending        <= bus.rc_read;
        rc_busy           <= bus.rc_read;
      end else if (rc_pending && bus.rc_readdatavalid) begin
        rc_pending <= 1'b0;
        rc_busy    <= 1'b0;
      end
      if (rc_reset) begin
        bus.rc_chipselect <= 1'b0;
        bus.rc_read       <= 1'b0;
        bus.rc_write      <= 1'b0;
        rc_busy           <= 1'b0;
        rc_pending        <= 1'b0;
      end
    end
  end
endmodule // csm_app

//--- csm_monitor.sv
module csm_monitor (
  input wire logic                          clock,             // Fabric clock
  input wire logic                          rst_n,             // System reset, active low
  input wire logic                          lmi_rd,            // Management read strobe
  input wire logic                          lmi_wr,            // Management write strobe
  input wire logic                          lmi_ack,           // Management acknowledge
  input wire logic [csm_pkg::LMI_DATA_W-1:0] lmi_rdata,        // Management read data
  input wire logic [csm_pkg::RC_ADDR_W-1:0] rc_address,        // Reconfiguration address
  input wire logic                          rc_chipselect,     // Reconfiguration select
  input wire logic                          rc_read,           // Reconfiguration read
  input wire logic                          rc_write,          // Reconfiguration write
  input wire logic [csm_pkg::RC_DATA_W-1:0] rc_writedata,      // Reconfiguration write data
  input wire logic                          rc_waitrequest,    // Slave stall
  input wire logic                          rc_readdatavalid,  // Read data valid
  input wire logic                          rc_rst_n           // Reconfiguration reset, active low
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence rc_take;
    rc_chipselect && (rc_read || rc_write) && !rc_waitrequest;
  endsequence
  sequence rc_rd_take;
    rc_chipselect && rc_read && !rc_waitrequest;
  endsequence
  sequence rc_stall;
    rc_chipselect && (rc_read || rc_write) && rc_waitrequest;
  endsequence

  ack_has_cause_a : assert property (lmi_ack |-> $past(lmi_rd || lmi_wr))
    else $error("acknowledge without a request");
  rdata_held_a : assert property (!lmi_rd |=> $stable(lmi_rdata))
    else $error("read data changed without a read");
  strobe_excl_a : assert property ((lmi_rd || lmi_wr) |-> !(lmi_rd && lmi_wr) ##1 !(lmi_rd || lmi_wr))
    else $error("management strobes overlap");
  stall_hold_a : assert property (rc_stall |=> rc_chipselect && $stable(rc_address)
    && $stable(rc_writedata) && $stable(rc_read) && $stable(rc_write))
    else $error("request changed while stalled");
  take_busy_a : assert property (rc_take |=> rc_waitrequest)
    else $error("no busy cycle after a take");
  read_valid_a : assert property (rc_rd_take |=> rc_readdatavalid)
    else $error("read data valid missing");
  valid_cause_a : assert property (rc_readdatavalid |-> $past(rc_chipselect && rc_read && !rc_waitrequest))
    else $error("read data valid without a read");
  rc_reset_idle_a : assert property (!rc_rst_n |-> rc_waitrequest && !rc_readdatavalid)
    else $error("slave active in reconfiguration reset");
endmodule // csm_monitor

//--- test_config_space_mgmt_access_ports.sv
module test_config_space_mgmt_access_ports;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst_n, cmd_rd, cmd_wr, wr_unlock, rc_rd, rc_wr, rc_reset;
  logic        link_req, link_wr, link_done, cmd_busy, cmd_done, cmd_fail, rc_busy, rc_rvalid;
  logic [11:0] cmd_addr, link_addr, a;
  logic [31:0] cmd_wdata, link_wdata, link_rdata, cmd_rdata, last, d;
  logic [12:0] link_busdev, busdev;
  logic [7:0]  rc_addr;
  logic [15:0] rc_wdata, rc_rdata;
  logic [31:0] mem [1024];
  logic [15:0] rcm [16];
  int          failures, check_count, cycles;

  csm_if bus_if (.clock(clock), .rst_n(rst_n));
  csm_device csm_device_inst (.bus(bus_if), .link_req(link_req), .link_wr(link_wr), .link_addr(link_addr),
    .link_wdata(link_wdata), .link_busdev(link_busdev), .link_rdata(link_rdata), .link_done(link_done),
    .busdev(busdev));
  // Short acknowledge wait keeps the collision case brief
  csm_app #(.ACK_WAIT(4)) csm_app_inst (.bus(bus_if), .cmd_rd(cmd_rd), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .wr_unlock(wr_unlock), .cmd_busy(cmd_busy), .cmd_done(cmd_done),
    .cmd_fail(cmd_fail), .cmd_rdata(cmd_rdata), .rc_rd(rc_rd), .rc_wr(rc_wr), .rc_addr(rc_addr),
    .rc_wdata(rc_wdata), .rc_reset(rc_reset), .rc_busy(rc_busy), .rc_rvalid(rc_rvalid), .rc_rdata(rc_rdata));
  csm_monitor csm_monitor_inst (.clock(clock), .rst_n(rst_n), .lmi_rd(bus_if.lmi_rd), .lmi_wr(bus_if.lmi_wr),
    .lmi_ack(bus_if.lmi_ack), .lmi_rdata(bus_if.lmi_rdata), .rc_address(bus_if.rc_address),
    .rc_chipselect(bus_if.rc_chipselect), .rc_read(bus_if.rc_read), .rc_write(bus_if.rc_write),
    .rc_writedata(bus_if.rc_writedata), .rc_waitrequest(bus_if.rc_waitrequest),
    .rc_readdatavalid(bus_if.rc_readdatavalid), .rc_rst_n(bus_if.rc_rst_n));

  task automatic close_out;
    if (failures == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] msk(input int i);
    if (i >= 10'h047 && i <= 10'h04A) return 32'hFFFF_FFFF;
    if (i == 1) return 32'h0000_FFFF;
    return 32'h0000_0000;
  endfunction

  // Read-only bits come from the reconfiguration values
  function automatic logic [31:0] exp_word(input int i);
    logic [31:0] ro;
    ro = (i < 8) ? {rcm[2*i+1], rcm[2*i]} : 32'h0000_0000;
    if (i >= 128) return 32'h0000_0000;
    return (mem[i] & msk(i)) | (ro & ~msk(i));
  endfunction

  // Kinds: 0 command end, 1 reconfiguration data, 2 reconfiguration idle, 3 link done
  task automatic settle(input int kind);
    for (int k = 0; k < 30; k++) begin
      if ((kind == 0 && (cmd_done || cmd_fail)) || (kind == 1 && rc_rvalid)
          || (kind == 2 && !rc_busy) || (kind == 3 && link_done)) break;
      @(posedge clock);
      #1;
    end
  endtask

  task automatic mgmt(input logic wr, input logic [11:0] ad, input logic [31:0] dt, input logic ok);
    cmd_rd = !wr; cmd_wr = wr; cmd_addr = ad; cmd_wdata = dt;
    @(negedge clock);
    cmd_rd = 1'b0; cmd_wr = 1'b0;
    settle(0);
    chk(32'(cmd_done), 32'(ok));
    chk(32'(cmd_busy), 32'h0);
    if (ok && wr) begin
      if (ad[11:2] < 128) mem[ad[11:2]] = dt;
      chk(32'(busdev), 32'(dt[12:0]));
      chk(bus_if.lmi_rdata, last);
    end
    if (ok && !wr) begin
      last = exp_word(ad[11:2]);
      chk(cmd_rdata, last);
      chk(bus_if.lmi_rdata, last);
    end
    @(negedge clock);
  endtask

  task automatic link(input logic wr, input logic [11:0] ad, input logic [31:0] dt, input logic [12:0] bd);
    link_req = 1'b1; link_wr = wr; link_addr = ad; link_wdata = dt; link_busdev = bd;
    @(negedge clock);
    link_req = 1'b0;
    settle(3);
    if (wr && ad[11:2] < 128) mem[ad[11:2]] = dt;
    if (wr) chk(32'(busdev), 32'(bd));
    else chk(link_rdata, exp_word(ad[11:2]));
    @(negedge clock);
  endtask

  task automatic rcacc(input logic wr, input logic [7:0] ad, input logic [15:0] dt);
    settle(2);
    rc_rd = !wr; rc_wr = wr; rc_addr = ad; rc_wdata = dt;
    @(negedge clock);
    rc_rd = 1'b0; rc_wr = 1'b0;
    settle(wr ? 2 : 1);
    if (wr && ad < 16) rcm[ad] = dt;
    if (!wr) chk(32'(rc_rvalid), 32'h1);
    if (!wr) chk(32'(rc_rdata), (ad < 16) ? 32'(rcm[ad]) : 32'h0);
    @(negedge clock);
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out;
    end
  end

  initial begin
    {rst_n, cmd_rd, cmd_wr, rc_rd, rc_wr, rc_reset, link_req, link_wr} = 8'h00;
    wr_unlock = 1'b1; cmd_addr = 12'h000; cmd_wdata = 32'h0; link_addr = 12'h000; link_wdata = 32'h0;
    link_busdev = 13'h0000; rc_addr = 8'h00; rc_wdata = 16'h0000; last = 32'h0;
    foreach (mem[i]) mem[i] = 32'h0;
    foreach (rcm[i]) rcm[i] = 16'h0000;
    void'($urandom(94));
    repeat (8) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    // Read-only half of word 1 follows the reconfiguration value
    rcacc(1'b1, 8'h03, 16'hA5C3);
    mgmt(1'b1, 12'h004, 32'hFFFF_FFFF, 1'b1);
    mgmt(1'b0, 12'h007, 32'h0, 1'b1);
    // Locked writes stay inside the header log
    wr_unlock = 1'b0;
    mgmt(1'b1, 12'h004, 32'h1234_5678, 1'b0);
    mgmt(1'b1, 12'h11C, 32'hC0DE_F00D, 1'b1);
    wr_unlock = 1'b1;
    link(1'b1, 12'h010, 32'h0000_0042, 13'h1ABC);
    // Link request on the take edge drops the acknowledge
    cmd_rd = 1'b1; cmd_addr = 12'h11C;
    @(negedge clock);
    cmd_rd = 1'b0; link_req = 1'b1; link_wr = 1'b0;
    @(negedge clock);
    link_req = 1'b0;
    settle(0);
    chk(32'(cmd_fail), 32'h1);
    chk(bus_if.lmi_rdata, last);
    @(negedge clock);
    rcacc(1'b1, 8'h00, 16'hBEEF);
    rc_reset = 1'b1;
    repeat (3) @(negedge clock);
    rc_reset = 1'b0;
    foreach (rcm[i]) rcm[i] = 16'h0000;
    // Request starts while the slave still stalls after reset
    rcacc(1'b1, 8'h01, 16'h00F0);
    rcacc(1'b0, 8'h00, 16'h0000);
    mgmt(1'b0, 12'h000, 32'h0, 1'b1);
    repeat (80) begin
      a = 12'($urandom) & (($urandom_range(0, 1) == 1) ? 12'h13F : 12'hFFF);
      d = $urandom;
      case ($urandom_range(0, 5))
        0: mgmt(1'b0, a, d, 1'b1);
        1: mgmt(1'b1, a, d, 1'b1);
        2: link(1'b0, a, d, 13'h0000);
        3: link(1'b1, a, d, 13'($urandom));
        4: rcacc(1'b1, 8'($urandom_range(0, 19)), d[15:0]);
        default: rcacc(1'b0, 8'($urandom_range(0, 19)), 16'h0000);
      endcase
    end
    close_out;
  end
endmodule // test_config_space_mgmt_access_ports
